// ==== logic/spk_ctl_regs.sv ====
// Decoder for the audio path and echo path control words of the speakerphone.
// Assumes a shifter elsewhere delivers each complete 16-bit word with a one-cycle strobe.
//
// Behaviour
// [RULE1] Mic preamp on at reset, off on zero
// [RULE2] Half-duplex while training or loop gain low
// [RULE3] Half-duplex allowed by default; disable bit blocks it
// [RULE4] Decay select feeds acoustic canceller only
// [RULE5] Decay codes: 00 none, 11 slight, 01 fastest
// [RULE6] AGC off at unity reference and below
// [RULE7] Gain 30 dB minus 3 dB per step, 1111 mutes
// [RULE8] Receive gain code resets to 18 dB
// [RULE9] Tx suppression on at reset, released by near speech
// [RULE10] Mode one: engage on far speech only
// [RULE11] Mode zero: engage whenever near end silent
// [RULE12] Acoustic code 00 adapts freely
// [RULE13] Acoustic code 01 zeroes, forces half-duplex
// [RULE14] Acoustic code 10 freezes coefficients
// [RULE15] Noise guard squelches transmit without near speech
// [RULE16] Controller drops noise guard with idle return
// [RULE17] Tap field splits taps between both cancellers
// [RULE18] Bit four blocks automatic line canceller re-engage
// [RULE19] Transmit gain same coding, resets to unity
// [RULE20] Rx suppression 24 dB without far speech
// [RULE21] Line coefficient field: normal, clear, freeze
// [RULE22] Low nibble selects target; bit zero zero
`timescale 1ns/1ps
`default_nettype none

module spk_ctl_regs
  import spk_ctl_pkg::*;
#(
  parameter int POLL_CYCLES = `SPK_POLL_CYC
) (
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rstn,
  // Control word from the serial shifter
  input  wire logic [15:0]     cw_word,
  input  wire logic            cw_stb,
  // DSP state
  input  wire spk_dsp_status_t dsp_status,
  // Decoded controls
  output var  spk_ctl_t        ctl
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Signed gain in dB for a volume code; 1111 is caught as mute elsewhere
  function automatic logic signed [6:0] spk_gain_db(input logic [3:0] code);
    logic [6:0] step3;
    step3 = {2'b00, code, 1'b0} + {3'b000, code};
    return `SPK_GAIN_TOP_DB - step3;
  endfunction : spk_gain_db

  function automatic logic spk_agc_on(input logic [3:0] code);
    return code < `SPK_GAIN_UNITY;
  endfunction : spk_agc_on

  function automatic logic [17:0] spk_taps(input logic [1:0] sel);
    case (sel)
      2'b00:   return `SPK_TAPS_SPLIT0;
      2'b01:   return `SPK_TAPS_SPLIT1;
      2'b10:   return `SPK_TAPS_SPLIT2;
      default: return `SPK_TAPS_SPLIT3;
    endcase
  endfunction : spk_taps

  // ****************************************
  // Polling of the control word
  // ****************************************

  logic [14:0]     poll_cnt_q;
  logic [14:0]     poll_cnt_d;
  logic            poll_tick;
  logic [15:0]     pend_q;
  logic [15:0]     pend_d;
  logic            pend_v_q;
  logic            pend_v_d;
  logic            apply_audio;
  logic            apply_echo;
  spk_audio_word_t audio_q;
  spk_audio_word_t audio_d;
  spk_echo_word_t  echo_q;
  spk_echo_word_t  echo_d;
  spk_ctl_t        ctl_d;

  assign poll_tick  = poll_cnt_q == 15'(POLL_CYCLES - 1);
  assign poll_cnt_d = poll_tick ? 15'h0000 : poll_cnt_q + 15'h0001;

  // A later word before the poll overwrites the earlier one, as the pins allow
  assign pend_d   = cw_stb ? cw_word : pend_q;
  assign pend_v_d = cw_stb | (pend_v_q & ~poll_tick);

  // Words with bit zero set, or other targets, are left to other decoders
  assign apply_audio = poll_tick & pend_v_q &
                       (pend_q[`SPK_ADDR_MSB:`SPK_ADDR_LSB] == `SPK_ADDR_AUDIO); // RULE22
  assign apply_echo  = poll_tick & pend_v_q &
                       (pend_q[`SPK_ADDR_MSB:`SPK_ADDR_LSB] == `SPK_ADDR_ECHO); // RULE22

  assign audio_d = apply_audio ? spk_audio_word_t'(pend_q) : audio_q;
  assign echo_d  = apply_echo  ? spk_echo_word_t'(pend_q)  : echo_q;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      poll_cnt_q <= 15'h0000;
      pend_q     <= 16'h0000;
      pend_v_q   <= 1'b0;
    end else begin
      poll_cnt_q <= poll_cnt_d;
      pend_q     <= pend_d;
      pend_v_q   <= pend_v_d;
    end
  end

  // ****************************************
  // Control word storage
  // ****************************************

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      audio_q <= spk_audio_word_t'(`SPK_AUDIO_RST); // RULE1 RULE8 RULE9 RULE11 RULE12 RULE15
      echo_q  <= spk_echo_word_t'(`SPK_ECHO_RST); // RULE19 RULE20 RULE21 RULE18
    end else begin
      audio_q <= audio_d;
      echo_q  <= echo_d;
    end
  end

  // ****************************************
  // Decode into controls
  // ****************************************

  wire logic near_sp      = dsp_status.near_speech;
  wire logic far_sp       = dsp_status.far_speech;
  wire logic acoustic_clr = audio_q.acoustic_coef_ctl == `SPK_COEF_CLEAR;
  wire logic acoustic_frz = audio_q.acoustic_coef_ctl == `SPK_COEF_FREEZE;
  wire logic line_clr     = echo_q.line_coef_ctl == `SPK_COEF_CLEAR;
  wire logic line_frz     = echo_q.line_coef_ctl == `SPK_COEF_FREEZE;

  // Half-duplex is wanted while the canceller cannot hold off howling
  wire logic hd_need = ~dsp_status.filter_trained | dsp_status.loop_gain_low
                       | acoustic_clr; // RULE2 RULE13
  wire logic hd_act  = hd_need & ~audio_q.halfduplex_off; // RULE3

  // Mode one waits for far speech; mode zero engages on near silence alone
  wire logic tx_sup_cond = audio_q.tx_squelch_mode ? far_sp : 1'b1; // RULE10 RULE11
  wire logic tx_sup      = ~audio_q.tx_squelch_off & ~near_sp & tx_sup_cond; // RULE9
  wire logic tx_guard    = ~audio_q.tx_squelch_mode & ~near_sp; // RULE15
  wire logic rx_sup      = ~echo_q.rx_squelch_off & ~far_sp; // RULE20

  wire logic [17:0] taps = spk_taps(echo_q.tap_split); // RULE17

  always_comb begin
    ctl_d = '0;
    ctl_d.mic_preamp_en     = audio_q.mic_preamp_en; // RULE1
    ctl_d.halfduplex_active = hd_act;
    // The line canceller has no graded update gain, so only the acoustic side sees it
    ctl_d.acoustic_decay_sel = audio_q.update_gain_decay_sel; // RULE4 RULE5
    ctl_d.rx_agc_en         = spk_agc_on(audio_q.rx_gain_code); // RULE6
    ctl_d.rx_mute           = audio_q.rx_gain_code == `SPK_GAIN_MUTE; // RULE7
    ctl_d.rx_gain_db        = spk_gain_db(audio_q.rx_gain_code); // RULE7
    ctl_d.tx_agc_en         = spk_agc_on(echo_q.tx_gain_code); // RULE19
    ctl_d.tx_mute           = echo_q.tx_gain_code == `SPK_GAIN_MUTE; // RULE19
    ctl_d.tx_gain_db        = spk_gain_db(echo_q.tx_gain_code); // RULE19
    ctl_d.tx_squelch_engage = tx_sup;
    ctl_d.tx_noise_squelch  = tx_guard;
    ctl_d.rx_squelch_engage = rx_sup;
    ctl_d.rx_squelch_db     = rx_sup ? `SPK_RX_SUPP_DB : 5'h00; // RULE20
    // Reserved code 11 adapts like normal so a stray write cannot stall training
    ctl_d.acoustic_coef_zero   = acoustic_clr; // RULE13 RULE12
    ctl_d.acoustic_coef_freeze = acoustic_frz; // RULE14
    ctl_d.line_coef_zero       = line_clr; // RULE21
    ctl_d.line_coef_freeze     = line_frz; // RULE21
    ctl_d.acoustic_taps        = taps[17:9]; // RULE17
    ctl_d.line_taps            = taps[8:0]; // RULE17
    ctl_d.tx_speech_threshold = echo_q.tx_speech_threshold;
    ctl_d.line_canceller_reengage_off = echo_q.line_canceller_reengage_off; // RULE18
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctl <= '0;
    end else begin
      ctl <= ctl_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  logic rst_seen_q;
  always_ff @(posedge clk_sys) begin
    rst_seen_q <= !rstn;
  end

  a_mic_reset_on: assert property ( // RULE1
    rst_seen_q && rstn |-> ##1 ctl.mic_preamp_en && ctl.rx_gain_db == 7'sd18
  ) else $error("mic preamp or rx gain wrong after reset");

  a_mic_write_zero: assert property ( // RULE1
    apply_audio && !pend_q[15] |-> ##2 !ctl.mic_preamp_en
  ) else $error("mic preamp not disabled by write");

  a_hd_blocked_off: assert property ( // RULE3
    audio_q.halfduplex_off |=> !ctl.halfduplex_active
  ) else $error("half-duplex entered while disabled");

  a_hd_untrained: assert property ( // RULE2
    !dsp_status.filter_trained && !audio_q.halfduplex_off |=> ctl.halfduplex_active
  ) else $error("no half-duplex while training");

  a_clear_forces_hd: assert property ( // RULE13
    apply_audio && pend_q[6:5] == 2'b01 && !pend_q[14] |-> ##2
      ctl.halfduplex_active && ctl.acoustic_coef_zero
  ) else $error("coefficient clear did not force half-duplex");

  a_gain_steps: assert property ( // RULE7
    apply_echo && pend_q[11:8] == 4'h4 |-> ##2 ctl.tx_gain_db == 7'sd18 && ctl.tx_agc_en
  ) else $error("tx gain step wrong");

  a_agc_at_unity: assert property ( // RULE6
    apply_audio && pend_q[11:8] >= 4'hA |-> ##2 !ctl.rx_agc_en
  ) else $error("rx agc left on at unity or below");

  a_tx_near_release: assert property ( // RULE9
    dsp_status.near_speech |=> !ctl.tx_squelch_engage && !ctl.tx_noise_squelch
  ) else $error("tx suppression held during near speech");

  a_tx_mode_far: assert property ( // RULE10
    audio_q.tx_squelch_mode && !dsp_status.far_speech |=> !ctl.tx_squelch_engage
  ) else $error("tx suppressor engaged without far speech");

  a_rx_supp_depth: assert property ( // RULE20
    !echo_q.rx_squelch_off && !dsp_status.far_speech |=> ctl.rx_squelch_db == 5'd24
  ) else $error("rx suppression depth wrong");

  a_tap_split: assert property ( // RULE17
    apply_echo && pend_q[13:12] == 2'b00 |-> ##2
      ctl.acoustic_taps == 9'd444 && ctl.line_taps == 9'd64
  ) else $error("tap split wrong");

  a_odd_word_ignored: assert property ( // RULE22
    poll_tick && pend_v_q && pend_q[0] |=> $stable(audio_q) && $stable(echo_q)
  ) else $error("word with bit zero set was applied");

  a_reengage_bit: assert property ( // RULE18
    apply_echo |-> ##2 ctl.line_canceller_reengage_off == $past(pend_q[4], 2)
  ) else $error("re-engage control not taken from bit four");

  a_decay_select: assert property ( // RULE5 RULE4
    apply_audio |-> ##2 ctl.acoustic_decay_sel == $past(pend_q[13:12], 2)
  ) else $error("decay select not taken from the audio word");

  a_rx_mute_code: assert property ( // RULE7
    apply_audio && pend_q[11:8] == 4'hF |-> ##2 ctl.rx_mute && !ctl.rx_agc_en
  ) else $error("rx path not muted by the top code");

  a_tx_unity_gain: assert property ( // RULE19
    apply_echo && pend_q[11:8] == 4'hA |-> ##2 ctl.tx_gain_db == 7'sh00 && !ctl.tx_agc_en
  ) else $error("tx gain wrong at the unity code");

  a_acoustic_freeze: assert property ( // RULE14
    apply_audio && pend_q[6:5] == 2'b10 |-> ##2
      ctl.acoustic_coef_freeze && !ctl.acoustic_coef_zero
  ) else $error("acoustic coefficients not frozen");

  a_acoustic_normal: assert property ( // RULE12
    apply_audio && pend_q[6:5] == 2'b00 |-> ##2
      !ctl.acoustic_coef_freeze && !ctl.acoustic_coef_zero
  ) else $error("acoustic coefficients not free to adapt");

  a_line_freeze: assert property ( // RULE21
    apply_echo && pend_q[6:5] == 2'b10 |-> ##2 ctl.line_coef_freeze && !ctl.line_coef_zero
  ) else $error("line coefficients not frozen");

  a_line_clear: assert property ( // RULE21
    apply_echo && pend_q[6:5] == 2'b01 |-> ##2 ctl.line_coef_zero && !ctl.line_coef_freeze
  ) else $error("line coefficients not cleared");

  a_guard_squelch: assert property ( // RULE15
    !audio_q.tx_squelch_mode && !dsp_status.near_speech |=> ctl.tx_noise_squelch
  ) else $error("noise guard not squelching a silent near end");

  a_tx_mode_zero: assert property ( // RULE11
    !audio_q.tx_squelch_mode && !audio_q.tx_squelch_off && !dsp_status.near_speech
      |=> ctl.tx_squelch_engage
  ) else $error("tx suppressor idle in mode zero without near speech");

  a_rx_supp_off: assert property ( // RULE20
    echo_q.rx_squelch_off |=> !ctl.rx_squelch_engage && ctl.rx_squelch_db == 5'h00
  ) else $error("rx suppression active while disabled");

  a_tx_supp_off: assert property ( // RULE9
    audio_q.tx_squelch_off |=> !ctl.tx_squelch_engage
  ) else $error("tx suppression active while disabled");

  a_hd_loop_low: assert property ( // RULE2
    dsp_status.loop_gain_low && !audio_q.halfduplex_off |=> ctl.halfduplex_active
  ) else $error("no half-duplex while loop gain is low");

  a_reset_defaults: assert property ( // RULE19 RULE17
    rst_seen_q && rstn |-> ##1 ctl.tx_gain_db == 7'sh00 &&
      ctl.acoustic_taps == 9'h13C && ctl.line_taps == 9'h0C0
  ) else $error("tx gain or tap split wrong after reset");

endmodule : spk_ctl_regs

`default_nettype wire

// ==== logic/spk_ctl_cfg.svh ====
// Offsets, field positions, reset words and timing for the speakerphone control words.
// Included by the package, which the control-word decoder imports; definitions only.
`ifndef SPK_CTL_CFG_SVH
`define SPK_CTL_CFG_SVH

// Target select in the low nibble of each control word
`define SPK_ADDR_LSB      0
`define SPK_ADDR_MSB      3
`define SPK_ADDR_AUDIO    4'h0
`define SPK_ADDR_ECHO     4'h2

// Reset words of the two control words
`define SPK_AUDIO_RST     16'hA400
`define SPK_ECHO_RST      16'h2A02

// Field codes
`define SPK_COEF_NORMAL   2'b00
`define SPK_COEF_CLEAR    2'b01
`define SPK_COEF_FREEZE   2'b10
`define SPK_GAIN_UNITY    4'hA
`define SPK_GAIN_MUTE     4'hF
`define SPK_GAIN_TOP_DB   7'h1E
`define SPK_RX_SUPP_DB    5'h18

// Tap splits, acoustic then line canceller
`define SPK_TAPS_SPLIT0   18'h3_7840
`define SPK_TAPS_SPLIT1   18'h2_F880
`define SPK_TAPS_SPLIT2   18'h2_78C0
`define SPK_TAPS_SPLIT3   18'h1_F900

// Polling interval of the control word
`define SPK_POLL_NS       125000
`define SPK_CLK_NS        4
`define SPK_POLL_CYC      (`SPK_POLL_NS / `SPK_CLK_NS)

`endif

// ==== logic/spk_ctl_pkg.sv ====
// Types shared by the speakerphone control-word decoder and its users.
// Assumes spk_ctl_cfg.svh is on the include path.
`include "spk_ctl_cfg.svh"

package spk_ctl_pkg;

  // Layout of the audio path control word
  typedef struct packed {
    logic       mic_preamp_en;
    logic       halfduplex_off;
    logic [1:0] update_gain_decay_sel;
    logic [3:0] rx_gain_code;
    logic       tx_squelch_off;
    logic [1:0] acoustic_coef_ctl;
    logic       tx_squelch_mode;
    logic [3:0] addr;
  } spk_audio_word_t;

  // Layout of the echo path control word
  typedef struct packed {
    logic [1:0] tx_speech_threshold;
    logic [1:0] tap_split;
    logic [3:0] tx_gain_code;
    logic       rx_squelch_off;
    logic [1:0] line_coef_ctl;
    logic       line_canceller_reengage_off;
    logic [3:0] addr;
  } spk_echo_word_t;

  // Speech and convergence state reported by the DSP core
  typedef struct packed {
    logic near_speech;
    logic far_speech;
    logic filter_trained;
    logic loop_gain_low;
  } spk_dsp_status_t;

  // Decoded controls handed to the audio paths and the cancellers
  typedef struct packed {
    logic              mic_preamp_en;
    logic              halfduplex_active;
    logic [1:0]        acoustic_decay_sel;
    logic              rx_agc_en;
    logic              rx_mute;
    logic signed [6:0] rx_gain_db;
    logic              tx_agc_en;
    logic              tx_mute;
    logic signed [6:0] tx_gain_db;
    logic              tx_squelch_engage;
    logic              tx_noise_squelch;
    logic              rx_squelch_engage;
    logic [4:0]        rx_squelch_db;
    logic              acoustic_coef_zero;
    logic              acoustic_coef_freeze;
    logic              line_coef_zero;
    logic              line_coef_freeze;
    logic [8:0]        acoustic_taps;
    logic [8:0]        line_taps;
    logic [1:0]        tx_speech_threshold;
    logic              line_canceller_reengage_off;
  } spk_ctl_t;

endpackage : spk_ctl_pkg

// ==== sim/spk_mcu_model.sv ====
// Model of the microcontroller that hands complete control words to the decoder.
// Assumes the bench calls send() and keeps writes a poll interval apart.
`timescale 1ns/1ps
`default_nettype none

module spk_mcu_model (
  // Clock
  input  wire logic        clk_sys,
  // Word towards the decoder
  output var  logic [15:0] cw_word,
  output var  logic        cw_stb
);
  initial begin
    cw_word = 16'h0000;
    cw_stb  = 1'b0;
  end

  // ********************
  // Word delivery
  // ********************
  // A variable gap models a prompt or a slow controller
  task automatic send(input logic [15:0] w, input int gap);
    repeat (gap) @(negedge clk_sys);
    @(negedge clk_sys);
    cw_word = w;
    cw_stb  = 1'b1;
    @(negedge clk_sys);
    cw_stb  = 1'b0;
    // Stale data is inverted so nothing can latch it by accident
    cw_word = ~w;
  endtask : send
endmodule : spk_mcu_model

`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the control-word decoder against a behavioural model.
// Assumes a short poll interval and the microcontroller model beside it.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import spk_ctl_pkg::*;
  localparam int POLL = 16;
  logic            clk_sys;
  logic            rstn;
  logic [15:0]     cw_word;
  logic            cw_stb;
  spk_dsp_status_t dsp_status;
  spk_ctl_t        ctl;
  int              bad_count;
  int              compares;
  logic [15:0]     aud_m;
  logic [15:0]     echo_m;
  logic [15:0]     w;
  logic [15:0]     words[$];

  spk_ctl_regs #(.POLL_CYCLES(POLL)) i_dut (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .cw_word   (cw_word),
    .cw_stb    (cw_stb),
    .dsp_status(dsp_status),
    .ctl       (ctl)
  );

  spk_mcu_model i_mcu (
    .clk_sys(clk_sys),
    .cw_word(cw_word),
    .cw_stb (cw_stb)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ********************
  // Reference model
  // ********************
  function automatic spk_ctl_t model(logic [15:0] a, logic [15:0] e, spk_dsp_status_t s);
    spk_ctl_t x;
    int       rc;
    int       tc;
    int       tp;
    rc = int'(a[11:8]);
    tc = int'(e[11:8]);
    tp = int'(e[13:12]);
    x = '0;
    x.mic_preamp_en = a[15];
    x.halfduplex_active = !a[14] && (!s.filter_trained || s.loop_gain_low || a[6:5] == 2'b01);
    x.acoustic_decay_sel = a[13:12];
    x.rx_agc_en = rc < 10;
    x.rx_mute = rc == 15;
    x.rx_gain_db = 7'(30 - 3 * rc);
    x.tx_agc_en = tc < 10;
    x.tx_mute = tc == 15;
    x.tx_gain_db = 7'(30 - 3 * tc);
    x.tx_squelch_engage = !a[7] && !s.near_speech && (a[4] ? s.far_speech : 1'b1);
    x.tx_noise_squelch = !a[4] && !s.near_speech;
    x.rx_squelch_engage = !e[7] && !s.far_speech;
    x.rx_squelch_db = x.rx_squelch_engage ? 5'h18 : 5'h00;
    x.acoustic_coef_zero = a[6:5] == 2'b01;
    x.acoustic_coef_freeze = a[6:5] == 2'b10;
    x.line_coef_zero = e[6:5] == 2'b01;
    x.line_coef_freeze = e[6:5] == 2'b10;
    x.acoustic_taps = 9'(444 - 64 * tp);
    x.line_taps = 9'(64 + 64 * tp);
    x.tx_speech_threshold = e[15:14];
    x.line_canceller_reengage_off = e[4];
    return x;
  endfunction : model

  task automatic check_ctl();
    spk_ctl_t exp;
    exp = model(aud_m, echo_m, dsp_status);
    compares++;
    if (ctl !== exp) begin
      bad_count++;
      $display("unexpected t=%0t got %h exp %h", $time, ctl, exp);
    end
  endtask : check_ctl

  task automatic give_verdict();
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // ********************
  // Tests
  // ********************
  initial begin
    bad_count = 0;
    compares = 0;
    rstn = 1'b0;
    dsp_status = '0;
    void'($urandom(53));
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    aud_m = 16'hA400;
    echo_m = 16'h2A02;
    repeat (3) @(negedge clk_sys);
    check_ctl();
    // Even steps hit the audio word, odd ones the echo word; every fifth is refused
    for (int i = 0; i < 40; i++) begin
      w = 16'($urandom);
      w[11:8] = 4'(i / 2);
      w[13:12] = 2'(i / 2);
      w[6:5] = 2'(i / 4);
      w[3:0] = (i % 2 == 0) ? 4'h0 : 4'h2;
      if (i % 5 == 4) begin
        w[3:0] = (i % 10 == 4) ? 4'h3 : 4'h4;
        // Idle return stays off in the target-4 words, as noise guard may still be on; target-3 words keep it random
        w[4] = w[4] & w[0];
      end
      words.push_back(w);
    end
    // Directed words reach tx 18 dB, which the sweep misses, and repeat taps 444/64, mute, freeze
    words.push_back(16'h0402);
    words.push_back(16'h2F20);
    words.push_back(16'h3A52);
    words.push_back(16'hD450);
    // Idle return only once the audio word above has dropped noise guard
    words.push_back(16'h0014);
    foreach (words[k]) begin
      dsp_status = 4'($urandom);
      i_mcu.send(words[k], int'($urandom % 3));
      if (words[k][3:0] == 4'h0) begin
        aud_m = words[k];
      end else if (words[k][3:0] == 4'h2) begin
        echo_m = words[k];
      end
      repeat (2 * POLL + 4) @(negedge clk_sys);
      check_ctl();
      dsp_status = 4'($urandom);
      repeat (2) @(negedge clk_sys);
      check_ctl();
    end
    // A reset after the writes must bring every field back to its default
    rstn = 1'b0;
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    aud_m = 16'hA400;
    echo_m = 16'h2A02;
    repeat (3) @(negedge clk_sys);
    check_ctl();
    give_verdict();
  end

  // Forty-five writes of about forty cycles each fit well inside this span
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
